// File: enclave_pkg.sv
// constants and types shared by the enclave leaf checker
package enclave_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_CMD = 8'h00;
    localparam logic [7:0] OFS_LEAF = 8'h04;
    localparam logic [7:0] OFS_COUNT_LO = 8'h08;
    localparam logic [7:0] OFS_COUNT_HI = 8'h0C;
    localparam logic [7:0] OFS_BASE = 8'h10;
    localparam logic [7:0] OFS_DATA = 8'h14;
    localparam logic [7:0] OFS_CONTEXT = 8'h18;
    localparam logic [7:0] OFS_SEG_LIMIT = 8'h1C;
    localparam logic [7:0] OFS_PAGE_WORD = 8'h20;
    localparam logic [7:0] OFS_PAGE_KEY = 8'h24;
    localparam logic [7:0] OFS_ACC_OUT = 8'h28;
    localparam logic [7:0] OFS_RESULT = 8'h2C;
    localparam logic [7:0] OFS_FLAGS = 8'h30;
    localparam logic [7:0] OFS_FAULT_ADDR = 8'h34;
    localparam logic [7:0] OFS_SEALED = 8'h38;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h3C;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h40;
    // bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // leaf indices in the accumulator
    localparam logic [31:0] LEAF_WRITEBACK = 32'h0000000B;
    localparam logic [31:0] LEAF_TRACK = 32'h0000000C;
    // alignment masks
    localparam logic [31:0] MASK_4K = 32'h00000FFF;
    localparam logic [31:0] MASK_32B = 32'h0000001F;
    localparam logic [31:0] MASK_8B = 32'h00000007;
    // context register fields
    localparam int CTX_CPL = 0;
    localparam int CTX_LONG = 2;
    localparam int CTX_IN_CACHE = 3;
    localparam int CTX_MAP_VALID = 4;
    localparam int CTX_TYPE = 5;
    localparam int CTX_TRK_BUSY = 8;
    localparam int CTX_TRK_PEND = 9;
    localparam int CTX_CONFLICT = 10;
    localparam int CTX_SLOT_IN_CACHE = 11;
    localparam logic [1:0] CPL_SUPER = 2'h0;
    localparam int CANON_LSB = 15;
    // interrupt status bits
    localparam int IRQ_DONE = 0;
    localparam int IRQ_FAULT = 1;
    // sealing unit
    localparam logic [2:0] SEAL_LAST = 3'h3;
    localparam int SEAL_ROT = 5;

    typedef enum logic [1:0] {S_IDLE = 2'b00, S_EVAL = 2'b01, S_SEAL = 2'b10} state_t;
    typedef enum logic [1:0] {F_NONE = 2'b00, F_GP = 2'b01, F_PF = 2'b10} fault_t;
    typedef struct packed {logic sf; logic of; logic af; logic pf; logic cf; logic zf;} flags_t;
    typedef struct packed {fault_t fault; logic [31:0] faddr; logic [31:0] acc; logic zf;} outcome_t;
    typedef struct packed {logic [31:0] word; logic [31:0] key;} seal_req_t;
endpackage

// File: page_seal_unit.sv
// keyed word scrambler protecting page data on write-out
`timescale 1ns/1ps
`default_nettype none
module page_seal_unit (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // request
    input wire logic start,
    input wire enclave_pkg::seal_req_t req,
    // answer
    output logic done,
    output logic [31:0] result
);
    import enclave_pkg::*;

    typedef struct packed {logic busy; logic [2:0] cnt; logic [31:0] x; logic [31:0] key; logic done;} seal_st_t;
    seal_st_t s, n;

    // one round: rotate, then mix in key plus round number
    always_comb begin
        n = s;
        n.done = 1'b0;
        if (!s.busy && start) begin
            n.busy = 1'b1;
            n.cnt = '0;
            n.x = req.word ^ req.key;
            n.key = req.key;
        end else if (s.busy) begin
            n.x = ((s.x << SEAL_ROT) | (s.x >> (32 - SEAL_ROT))) ^ (s.key + {29'h0, s.cnt});
            n.cnt = s.cnt + 3'h1;
            if (s.cnt == SEAL_LAST) begin
                n.busy = 1'b0;
                n.done = 1'b1;
            end
        end
    end

    // state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign done = s.done;
    assign result = s.x;
endmodule // page_seal_unit
`default_nettype wire

// File: enclave_track_evict_checks.sv
// enclave leaf checker: tracking activation and page write-back front end
//
// The placing of the registers and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module enclave_track_evict_checks #(
    parameter logic [31:0] PREV_TRK_CODE = 32'h00000001,
    parameter logic [2:0] CONTROL_TYPE = 3'h0
) (
    // clock and reset
    input wire logic CLK_SYS,
    input wire logic RST_N,
    // axi4-lite write
    input wire logic [7:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    // axi4-lite read
    input wire logic [7:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    // interrupt
    output logic IRQ
);
    import enclave_pkg::*;
    typedef struct packed {
        state_t st;
        logic aw_h;
        logic [7:0] awa;
        logic w_h;
        logic [31:0] wd;
        logic [3:0] ws;
        logic bv;
        logic [1:0] br;
        logic rv;
        logic [31:0] rd;
        logic [1:0] rr;
        logic [31:0] leaf;
        logic [31:0] cnt_lo;
        logic [31:0] cnt_hi;
        logic [31:0] base;
        logic [31:0] data;
        logic [31:0] ctx;
        logic [31:0] limit;
        logic [31:0] word;
        logic [31:0] key;
        logic [31:0] acc;
        logic [31:0] faddr;
        logic [31:0] sealed;
        fault_t fault;
        flags_t flags;
        logic [1:0] irq_st;
        logic [1:0] irq_mask;
    } regs_t;
    regs_t r, n;
    outcome_t ev;
    logic seal_go;
    logic seal_done;
    logic [31:0] seal_res;
    seal_req_t seal_req;
    // ***************************************
    // helpers
    // ***************************************
    function automatic logic is_aligned(input logic [31:0] a, input logic [31:0] m);
        return (a & m) == 32'h0;
    endfunction
    function automatic logic is_canonical(input logic [31:0] hi);
        return (&hi[31:CANON_LSB]) | ~(|hi[31:CANON_LSB]);
    endfunction
    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d, input logic [3:0] b);
        logic [31:0] m;
        m = o;
        for (int i = 0; i < 4; i++) begin
            if (b[i]) begin
                m[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return m;
    endfunction
    // checks of one leaf in the documented order
    function automatic outcome_t evaluate(input regs_t s);
        outcome_t o;
        logic lng;
        logic over;
        o = '{fault: F_NONE, faddr: s.cnt_lo, acc: 32'h0, zf: 1'b0};
        lng = s.ctx[CTX_LONG];
        over = (s.cnt_lo > s.limit) || (s.leaf == LEAF_WRITEBACK && (s.base > s.limit || s.data > s.limit));
        if (s.leaf != LEAF_TRACK && s.leaf != LEAF_WRITEBACK) begin
            o.fault = F_GP;
        end else if (s.ctx[CTX_CPL +: 2] != CPL_SUPER) begin
            o.fault = F_GP;
        end else if (lng && !is_canonical(s.cnt_hi)) begin
            o.fault = F_GP;
        end else if (!lng && over) begin
            o.fault = F_GP;
        end else if (!is_aligned(s.cnt_lo, MASK_4K)) begin
            o.fault = F_GP;
        end else if (s.leaf == LEAF_TRACK) begin
            if (!s.ctx[CTX_IN_CACHE]) begin
                o.fault = F_PF;
            end else if (s.ctx[CTX_TRK_BUSY]) begin
                o.fault = F_GP;
            end else if (s.ctx[CTX_CONFLICT]) begin
                o.fault = F_GP;
            end else if (!s.ctx[CTX_MAP_VALID]) begin
                o.fault = F_PF;
            end else if (s.ctx[CTX_TYPE +: 3] != CONTROL_TYPE) begin
                o.fault = F_PF;
            end else if (s.ctx[CTX_TRK_PEND]) begin
                o.acc = PREV_TRK_CODE;
                o.zf = 1'b1;
            end
        end else begin
            // info in base, page in count, slot in data
            if (!is_aligned(s.base, MASK_32B)) begin
                o.fault = F_GP;
            end else if (!s.ctx[CTX_IN_CACHE]) begin
                o.fault = F_PF;
            end else if (!is_aligned(s.data, MASK_8B)) begin
                o.fault = F_GP;
            end else if (!s.ctx[CTX_SLOT_IN_CACHE]) begin
                o.fault = F_PF;
                o.faddr = s.data;
            end else if (s.ctx[CTX_CONFLICT]) begin
                o.fault = F_GP;
            end else if (!s.ctx[CTX_MAP_VALID]) begin
                o.fault = F_PF;
            end
        end
        return o;
    endfunction
    // ***************************************
    // next state
    // ***************************************
    always_comb begin
        n = r;
        seal_go = 1'b0;
        ev = evaluate(r);
        // write channel capture, either order
        if (S_AXI_AWVALID && !r.aw_h) begin
            n.aw_h = 1'b1;
            n.awa = S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && !r.w_h) begin
            n.w_h = 1'b1;
            n.wd = S_AXI_WDATA;
            n.ws = S_AXI_WSTRB;
        end
        if (r.bv && S_AXI_BREADY) begin
            n.bv = 1'b0;
        end
        // register write once both halves are held
        if (r.aw_h && r.w_h && !r.bv) begin
            n.aw_h = 1'b0;
            n.w_h = 1'b0;
            n.bv = 1'b1;
            n.br = RESP_OKAY;
            case (r.awa)
                OFS_CMD: begin
                    if (r.ws[0] && r.wd[0] && r.st == S_IDLE) begin
                        n.st = S_EVAL;
                    end
                end
                OFS_LEAF: n.leaf = merge(r.leaf, r.wd, r.ws);
                OFS_COUNT_LO: n.cnt_lo = merge(r.cnt_lo, r.wd, r.ws);
                OFS_COUNT_HI: n.cnt_hi = merge(r.cnt_hi, r.wd, r.ws);
                OFS_BASE: n.base = merge(r.base, r.wd, r.ws);
                OFS_DATA: n.data = merge(r.data, r.wd, r.ws);
                OFS_CONTEXT: n.ctx = merge(r.ctx, r.wd, r.ws);
                OFS_SEG_LIMIT: n.limit = merge(r.limit, r.wd, r.ws);
                OFS_PAGE_WORD: n.word = merge(r.word, r.wd, r.ws);
                OFS_PAGE_KEY: n.key = merge(r.key, r.wd, r.ws);
                OFS_FLAGS: n.flags = flags_t'(6'(merge({26'h0, r.flags}, r.wd, r.ws)));
                OFS_IRQ_MASK: n.irq_mask = 2'(merge({30'h0, r.irq_mask}, r.wd, r.ws));
                OFS_ACC_OUT, OFS_RESULT, OFS_FAULT_ADDR, OFS_SEALED, OFS_IRQ_STAT: ;
                default: n.br = RESP_SLVERR;
            endcase
        end
        // read channel
        if (r.rv && S_AXI_RREADY) begin
            n.rv = 1'b0;
        end
        if (S_AXI_ARVALID && !r.rv) begin
            n.rv = 1'b1;
            n.rr = RESP_OKAY;
            n.rd = 32'h0;
            case (S_AXI_ARADDR)
                OFS_CMD: n.rd = {31'h0, r.st != S_IDLE};
                OFS_LEAF: n.rd = r.leaf;
                OFS_COUNT_LO: n.rd = r.cnt_lo;
                OFS_COUNT_HI: n.rd = r.cnt_hi;
                OFS_BASE: n.rd = r.base;
                OFS_DATA: n.rd = r.data;
                OFS_CONTEXT: n.rd = r.ctx;
                OFS_SEG_LIMIT: n.rd = r.limit;
                OFS_PAGE_WORD: n.rd = r.word;
                OFS_PAGE_KEY: n.rd = r.key;
                OFS_ACC_OUT: n.rd = r.acc;
                OFS_RESULT: n.rd = {30'h0, r.fault};
                OFS_FLAGS: n.rd = {26'h0, r.flags};
                OFS_FAULT_ADDR: n.rd = r.faddr;
                OFS_SEALED: n.rd = r.sealed;
                OFS_IRQ_STAT: begin
                    n.rd = {30'h0, r.irq_st};
                    n.irq_st = 2'h0; // read clears, events below win
                end
                OFS_IRQ_MASK: n.rd = {30'h0, r.irq_mask};
                default: n.rr = RESP_SLVERR;
            endcase
        end
        // leaf sequencer
        case (r.st)
            S_IDLE: ;
            S_EVAL: begin
                n.fault = ev.fault;
                if (ev.fault != F_NONE) begin
                    n.faddr = ev.faddr;
                    n.irq_st[IRQ_FAULT] = 1'b1;
                    n.irq_st[IRQ_DONE] = 1'b1;
                    n.st = S_IDLE;
                end else begin
                    n.acc = ev.acc;
                    n.flags = '0;
                    n.flags.zf = ev.zf;
                    if (r.leaf == LEAF_WRITEBACK) begin
                        seal_go = 1'b1;
                        n.st = S_SEAL;
                    end else begin
                        n.irq_st[IRQ_DONE] = 1'b1;
                        n.st = S_IDLE;
                    end
                end
            end
            S_SEAL: begin
                if (seal_done) begin
                    n.sealed = seal_res;
                    n.irq_st[IRQ_DONE] = 1'b1;
                    n.st = S_IDLE;
                end
            end
            default: n.st = S_IDLE;
        endcase
    end

    // state register
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    // ***************************************
    // sealing unit and outputs
    // ***************************************
    assign seal_req = '{word: r.word, key: r.key};
    page_seal_unit u_seal (
        .clk(CLK_SYS),
        .rst_n(RST_N),
        .start(seal_go),
        .req(seal_req),
        .done(seal_done),
        .result(seal_res)
    );
    assign S_AXI_AWREADY = !r.aw_h;
    assign S_AXI_WREADY = !r.w_h;
    assign S_AXI_BVALID = r.bv;
    assign S_AXI_BRESP = r.br;
    assign S_AXI_ARREADY = !r.rv;
    assign S_AXI_RVALID = r.rv;
    assign S_AXI_RDATA = r.rd;
    assign S_AXI_RRESP = r.rr;
    assign IRQ = |(r.irq_st & r.irq_mask);
    // ***************************************
    // assertions
    // ***************************************
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);
    logic ev_trk;
    logic pre_ok;
    logic trk_ok;
    assign ev_trk = r.st == S_EVAL && r.leaf == LEAF_TRACK;
    assign pre_ok = r.ctx[CTX_CPL +: 2] == CPL_SUPER && r.ctx[CTX_LONG] && is_canonical(r.cnt_hi);
    assign trk_ok = ev_trk && pre_ok && is_aligned(r.cnt_lo, MASK_4K) && r.ctx[CTX_IN_CACHE]
        && !r.ctx[CTX_TRK_BUSY] && !r.ctx[CTX_CONFLICT] && r.ctx[CTX_MAP_VALID]
        && r.ctx[CTX_TYPE +: 3] == CONTROL_TYPE;
    property p_cpl;
        r.st == S_EVAL && r.ctx[CTX_CPL +: 2] != CPL_SUPER |=> r.fault == F_GP && r.st == S_IDLE;
    endproperty
    a_cpl: assert property (p_cpl) else $error("nonzero privilege not refused");
    property p_align;
        ev_trk && pre_ok && !is_aligned(r.cnt_lo, MASK_4K) |=> r.fault == F_GP;
    endproperty
    a_align: assert property (p_align) else $error("unaligned operand not refused");
    property p_cache;
        ev_trk && pre_ok && is_aligned(r.cnt_lo, MASK_4K) && !r.ctx[CTX_IN_CACHE]
            |=> r.fault == F_PF && r.faddr == $past(r.cnt_lo);
    endproperty
    a_cache: assert property (p_cache) else $error("page fault address wrong");
    property p_busy;
        ev_trk && pre_ok && is_aligned(r.cnt_lo, MASK_4K) && r.ctx[CTX_IN_CACHE] && r.ctx[CTX_TRK_BUSY]
            |=> r.fault == F_GP;
    endproperty
    a_busy: assert property (p_busy) else $error("busy tracking not refused");
    property p_prev;
        trk_ok && r.ctx[CTX_TRK_PEND] |=> r.acc == PREV_TRK_CODE && r.flags.zf && r.fault == F_NONE;
    endproperty
    a_prev: assert property (p_prev) else $error("pending tracking code wrong");
    property p_ok;
        trk_ok && !r.ctx[CTX_TRK_PEND] |=> r.acc == 32'h0 && !r.flags.zf;
    endproperty
    a_ok: assert property (p_ok) else $error("success outcome wrong");
    property p_clr;
        r.st != S_IDLE ##1 r.st == S_IDLE && r.fault == F_NONE |-> r.flags[5:1] == 5'h00;
    endproperty
    a_clr: assert property (p_clr) else $error("arithmetic flags not cleared");
    property p_limit;
        r.st == S_EVAL && r.leaf == LEAF_TRACK && r.ctx[CTX_CPL +: 2] == CPL_SUPER && !r.ctx[CTX_LONG]
            && r.cnt_lo > r.limit |=> r.fault == F_GP;
    endproperty
    a_limit: assert property (p_limit) else $error("segment limit not enforced");
    property p_canon;
        r.st == S_EVAL && r.ctx[CTX_CPL +: 2] == CPL_SUPER && r.ctx[CTX_LONG] && !is_canonical(r.cnt_hi)
            |=> r.fault == F_GP;
    endproperty
    a_canon: assert property (p_canon) else $error("noncanonical address not refused");
    property p_seal;
        r.st == S_SEAL |-> ##[1:6] r.st == S_IDLE && r.irq_st[IRQ_DONE];
    endproperty
    a_seal: assert property (p_seal) else $error("write-back never finished");
    c_track_ok: cover property (trk_ok && !r.ctx[CTX_TRK_PEND]);
    c_track_prev: cover property (trk_ok && r.ctx[CTX_TRK_PEND]);
    c_writeback: cover property (r.st == S_SEAL ##[1:6] r.st == S_IDLE);
    c_irq: cover property (IRQ && r.irq_st[IRQ_FAULT]);
endmodule // enclave_track_evict_checks
`default_nettype wire

// File: sw_leaf_issuer.sv
// software-side axi4-lite master issuing enclave leaf operations
`timescale 1ns/1ps
`default_nettype none
module sw_leaf_issuer (
    // clock
    input wire logic clk,
    // write channels
    output var logic [7:0] awaddr,
    output var logic awvalid,
    input wire logic awready,
    output var logic [31:0] wdata,
    output var logic [3:0] wstrb,
    output var logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    output var logic bready,
    // read channels
    output var logic [7:0] araddr,
    output var logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    output var logic rready
);
    import enclave_pkg::*;
    // idle bus from time zero
    initial begin
        {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
        {araddr, arvalid, rready} = '0;
    end
    // ********************************
    // bus cycles
    // ********************************
    // one write; ready judged before the edge that takes it, payload inverted once released
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ta, tw, tb;
        @(posedge clk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wstrb <= 4'hF;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(negedge clk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bvalid;
            r = bresp;
            @(posedge clk);
            if (ta) begin
                awvalid <= 1'b0;
                awaddr <= ~a;
            end
            if (tw) begin
                wvalid <= 1'b0;
                wdata <= ~d;
            end
            if (tb) begin
                bready <= 1'b0;
                break;
            end
        end
    endtask
    // one read; data taken at the edge where rvalid is seen
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ta, tv;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(negedge clk);
            ta = arvalid && arready;
            tv = rvalid;
            d = rdata;
            r = rresp;
            @(posedge clk);
            if (ta) begin
                arvalid <= 1'b0;
                araddr <= ~a;
            end
            if (tv) begin
                rready <= 1'b0;
                break;
            end
        end
    endtask
    // operand registers first, then the start command
    task automatic issue(input logic [31:0] lf, lo, hi, base, dat, ctx, lim);
        logic [1:0] r;
        wr(OFS_LEAF, lf, r);
        wr(OFS_COUNT_LO, lo, r);
        wr(OFS_COUNT_HI, hi, r);
        wr(OFS_BASE, base, r);
        wr(OFS_DATA, dat, r);
        wr(OFS_SEG_LIMIT, lim, r);
        wr(OFS_CONTEXT, ctx, r);
        wr(OFS_CMD, 32'h00000001, r);
    endtask
endmodule // sw_leaf_issuer
`default_nettype wire

// File: tb.sv
// self-checking bench for the enclave leaf checker
`timescale 1ns/1ps
`default_nettype none
module tb;
    import enclave_pkg::*;
    logic clk_sys, rst_n, irq;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, lf, lo, hi, lim, ctx, fl, mk, acc, pw, pk, d;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, r;
    logic zf;
    int res, n_fail, n_tests;
    enclave_track_evict_checks enclave_track_evict_checks_i (.CLK_SYS(clk_sys), .RST_N(rst_n),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
        .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
        .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
        .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
        .S_AXI_RREADY(rready), .IRQ(irq));
    sw_leaf_issuer sw_leaf_issuer_i (.clk(clk_sys), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready));
    // ********************************
    // helpers
    // ********************************
    // 40 ns system clock
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic rdc(input logic [7:0] a, input string nm, input logic [31:0] exp);
        logic [31:0] v;
        logic [1:0] rr;
        sw_leaf_issuer_i.rd(a, v, rr);
        chk(nm, v, exp);
    endtask
    // poll the busy bit, bounded
    task automatic wait_idle;
        logic [31:0] v;
        logic [1:0] rr;
        for (int n = 0; n < 40; n++) begin
            sw_leaf_issuer_i.rd(OFS_CMD, v, rr);
            if (v[0] === 1'b0) break;
        end
        chk("idle after leaf", v, 32'h0);
    endtask
    function automatic logic rb(input int n);
        return ($urandom % n) == 0;
    endfunction
    // reference scrambler for the sealed word
    function automatic logic [31:0] seal(input logic [31:0] w, input logic [31:0] k);
        logic [31:0] x;
        x = w ^ k;
        for (int i = 0; i < 4; i++) x = {x[26:0], x[31:27]} ^ (k + 32'(i));
        return x;
    endfunction
    task automatic end_sim;
        $display("tests %0d failures %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // hang guard
    initial begin
        repeat (40000) @(posedge clk_sys);
        n_fail++;
        end_sim;
    end
    // ********************************
    // main sequence
    // ********************************
    initial begin
        rst_n = 1'b0;
        acc = 32'h0;
        void'($urandom(32'h0097));
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        // unmapped places answer with an error
        sw_leaf_issuer_i.wr(8'h44, 32'h12345678, r);
        chk("unmapped write resp", {30'h0, r}, {30'h0, RESP_SLVERR});
        sw_leaf_issuer_i.rd(8'h80, d, r);
        chk("unmapped read resp", {30'h0, r}, {30'h0, RESP_SLVERR});
        // random track operations against the reference model
        for (int i = 0; i < 30; i++) begin
            lf = rb(8) ? 32'h0000000D : LEAF_TRACK;
            ctx = {21'h0, rb(6), rb(3), rb(6), rb(6) ? 3'($urandom % 7 + 1) : 3'h0, !rb(6), !rb(6), rb(2),
                rb(6) ? 2'($urandom % 3 + 1) : 2'h0};
            lo = {20'($urandom), rb(6) ? 12'h800 : 12'h0};
            hi = rb(6) ? 32'h00010000 : (rb(2) ? 32'hFFFF8000 : 32'h0);
            lim = rb(5) ? 32'($urandom) : 32'hFFFFFFFF;
            fl = 32'($urandom % 64);
            mk = 32'($urandom % 4);
            sw_leaf_issuer_i.wr(OFS_FLAGS, fl, r);
            sw_leaf_issuer_i.wr(OFS_IRQ_MASK, mk, r);
            sw_leaf_issuer_i.issue(lf, lo, hi, 32'h0, 32'h0, ctx, lim);
            wait_idle;
            res = 0;
            zf = 1'b0;
            if (lf != LEAF_TRACK || ctx[1:0] != 2'h0 || (ctx[2] && hi[31:15] != 17'h0 && hi[31:15] != 17'h1FFFF)
                || (!ctx[2] && lo > lim) || lo[11:0] != 12'h0) res = 1;
            else if (!ctx[3]) res = 2;
            else if (ctx[8] || ctx[10]) res = 1;
            else if (!ctx[4] || ctx[7:5] != 3'h0) res = 2;
            else zf = ctx[9];
            if (res == 0) acc = zf ? 32'h1 : 32'h0;
            rdc(OFS_RESULT, "result", 32'(res));
            if (res == 2) rdc(OFS_FAULT_ADDR, "fault address", lo);
            rdc(OFS_ACC_OUT, "accumulator", acc);
            rdc(OFS_FLAGS, "flags", res != 0 ? fl : {31'h0, zf});
            chk("irq level", {31'h0, irq}, {31'h0, |(mk[1:0] & {res != 0, 1'b1})});
            rdc(OFS_IRQ_STAT, "irq status", {30'h0, res != 0, 1'b1});
            rdc(OFS_IRQ_STAT, "irq status cleared", 32'h0);
            chk("irq after clear", {31'h0, irq}, 32'h0);
        end
        // page write-back with sealing
        pw = $urandom;
        pk = $urandom;
        sw_leaf_issuer_i.wr(OFS_PAGE_WORD, pw, r);
        sw_leaf_issuer_i.wr(OFS_PAGE_KEY, pk, r);
        sw_leaf_issuer_i.wr(OFS_FLAGS, 32'h3F, r);
        sw_leaf_issuer_i.issue(LEAF_WRITEBACK, 32'h5000, 32'h0, 32'h40, 32'h8, 32'h818, 32'hFFFFFFFF);
        rdc(OFS_CMD, "busy while sealing", 32'h1);
        wait_idle;
        rdc(OFS_RESULT, "writeback result", 32'h0);
        rdc(OFS_SEALED, "sealed word", seal(pw, pk));
        rdc(OFS_ACC_OUT, "writeback accumulator", 32'h0);
        rdc(OFS_FLAGS, "writeback flags", 32'h0);
        end_sim;
    end
endmodule // tb
`default_nettype wire
